// >>> core/gpio_port_change_notify.sv
// How it works
// - polarity bit 0 drives transceiver enable low in transmit, 1 drives it high
// - pin-function bits 11:4 are written zero; their reads mean nothing
// - direction bit 0 makes a free pin input, 1 makes it output
// - set register write drives output pins high for ones, low for zeros
// - set register writes leave input pins untouched
// - clear register ones drive output pins low; zeros keep the level
// - set and clear bits 11:6 are unused and written zero
// - level readback register returns present level of all six pins
// - mask bit 0 lets a pin change send a notification, 1 stops it
// - mask affects neither readback nor pin levels carried in packets
// - format bit 0 picks standard data layout, 1 picks extended pin layout
// - packet starts with fixed eight-byte header: a1, 20, zero, zero, length 2
// - two-byte data field follows at byte 8, little-endian
// - standard data: overrun, parity, framing, ring, break, dsr, cd in bits 6:0
// - overrun bit reports received data lost to an internal overrun
// - extended data adds pins 5,4,3,0,2,1 at bits 14,13,12,11,9,8
// - pull-up bits enable pull-ups on pins 5:0, receive bit 6, transmit bit 7
// - modes 001, 010 take flow-control pins; 011 and 100 give pin 5 to transceiver
module gpio_port_change_notify
  import gpio_notify_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // general pins
  input  wire logic [PINS-1:0] general_pin_n_in,
  output logic      [PINS-1:0] general_pin_n_out,
  output logic      [PINS-1:0] general_pin_n_oe,
  output logic      [7:0]      pullup_en,
  // uart side
  input  wire logic            uart_transmitting,
  input  wire logic            uart_addr_matched,
  input  wire logic            rts_flow_level,
  input  wire logic            dtr_flow_level,
  input  wire logic [6:0]      uart_line_status,
  // interrupt endpoint byte stream
  output logic      [7:0]      notify_tdata,
  output logic                 notify_tvalid,
  output logic                 notify_tlast,
  input  wire logic            notify_tready,
  input  wire logic            uart_status_event
);
  if (PINS != NUM_PINS) begin : g_bad_pins
    $error("pin map is fixed at six general pins");
  end

  logic [REG_W-1:0] func_reg;
  logic [REG_W-1:0] dir_reg;
  logic [PINS-1:0]  drive_reg;
  logic [PINS-1:0]  drive_next;
  logic [PINS-1:0]  mask_reg;
  logic             format_reg;
  logic [7:0]       pullup_reg;
  logic [PINS-1:0]  pin_sync_lvl;
  logic [PINS-1:0]  pin_prev_reg;
  logic             pending_reg;
  logic [2:0]       prime_reg;
  logic [31:0]      prdata_reg;

  // ---------------- apb decode
  wire        wr_en   = psel && penable && pwrite;
  wire        rd_en   = psel && penable && !pwrite;
  wire        hit_func   = (paddr == OFF_FUNC);
  wire        hit_dir    = (paddr == OFF_DIR);
  wire        hit_set    = (paddr == OFF_SET);
  wire        hit_clear  = (paddr == OFF_CLEAR);
  wire        hit_level  = (paddr == OFF_LEVEL);
  wire        hit_mask   = (paddr == OFF_MASK);
  wire        hit_format = (paddr == OFF_FORMAT);
  wire        hit_pullup = (paddr == OFF_PULLUP);
  wire        hit_ustat  = (paddr == OFF_UART_STAT);
  wire        hit_any    = hit_func | hit_dir | hit_set | hit_clear | hit_level |
                           hit_mask | hit_format | hit_pullup | hit_ustat;
  wire        wr_set     = wr_en && hit_set;
  wire        wr_clear   = wr_en && hit_clear;

  // ---------------- pin-function decode
  wire [2:0]  mode       = func_reg[FUNC_MODE_LSB +: FUNC_MODE_W];
  wire        xcvr_pol   = func_reg[FUNC_POL_BIT];
  wire        mode_rc    = (mode == MODE_RTS_CTS);
  wire        mode_dd    = (mode == MODE_DTR_DSR);
  wire        mode_xc    = (mode == MODE_XCVR_TX) || (mode == MODE_XCVR_ADDR);

  // pins taken by a dedicated role ignore direction and drive registers
  wire [PINS-1:0] dedicated = {mode_rc | mode_xc, mode_rc, mode_dd, mode_dd, 2'b00};

  // mode 100 only turns the transceiver round after an address match
  wire        xcvr_active = uart_transmitting &&
                            ((mode == MODE_XCVR_TX) || uart_addr_matched);
  wire        transceiver_direction_out = xcvr_pol ? xcvr_active : !xcvr_active;

  // ---------------- pin outputs
  always_comb begin
    general_pin_n_out = drive_reg;
    general_pin_n_oe  = dir_reg[PINS-1:0] & ~dedicated;
    if (mode_rc) begin
      general_pin_n_out[5] = rts_flow_level;
      general_pin_n_oe[5]  = 1'b1;
      general_pin_n_oe[4]  = 1'b0;
    end
    if (mode_dd) begin
      general_pin_n_out[3] = dtr_flow_level;
      general_pin_n_oe[3]  = 1'b1;
      general_pin_n_oe[2]  = 1'b0;
    end
    if (mode_xc) begin
      general_pin_n_out[5] = transceiver_direction_out;
      general_pin_n_oe[5]  = 1'b1;
    end
  end

  assign pullup_en = pullup_reg;

  // ---------------- drive latch, per pin
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_drive
      wire is_out = dir_reg[g] && !dedicated[g];
      always_comb begin
        drive_next[g] = drive_reg[g];
        if (wr_set && is_out) begin
          drive_next[g] = pwdata[g];
        end else if (wr_clear && is_out && pwdata[g]) begin
          drive_next[g] = 1'b0;
        end
      end
    end
  endgenerate

  // ---------------- register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg   <= RST_FUNC;
      dir_reg    <= RST_DIR;
      drive_reg  <= RST_DRIVE[PINS-1:0];
      mask_reg   <= RST_MASK[PINS-1:0];
      format_reg <= RST_FORMAT[0];
      pullup_reg <= RST_PULLUP[7:0];
    end else begin
      drive_reg <= drive_next;
      if (wr_en && hit_func) begin
        // upper bits are kept as written; they steer nothing
        func_reg <= pwdata[REG_W-1:0];
      end
      if (wr_en && hit_dir) begin
        dir_reg <= pwdata[REG_W-1:0];
      end
      if (wr_en && hit_mask) begin
        mask_reg <= pwdata[PINS-1:0];
      end
      if (wr_en && hit_format) begin
        format_reg <= pwdata[0];
      end
      if (wr_en && hit_pullup) begin
        pullup_reg <= pwdata[7:0];
      end
    end
  end

  // ---------------- pin sampling
  pin_sync #(
    .W (PINS)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (general_pin_n_in),
    .q     (pin_sync_lvl)
  );

  // history is trusted only once the synchroniser and history have filled,
  // so the reset-to-idle step of the pins is never seen as a change
  wire [PINS-1:0] changed    = (pin_sync_lvl ^ pin_prev_reg) & {PINS{prime_reg[2]}};
  wire            pin_event  = |(changed & ~mask_reg);
  wire            trigger    = pin_event || uart_status_event;

  // ---------------- packet data field
  wire [15:0] std_field = {9'h000, uart_line_status};
  wire [15:0] ext_field = {1'b0,
                           pin_sync_lvl[5], pin_sync_lvl[4], pin_sync_lvl[3],
                           pin_sync_lvl[0], 1'b0,
                           pin_sync_lvl[2], pin_sync_lvl[1],
                           1'b0, uart_line_status};
  wire [15:0] field_sel = format_reg ? ext_field : std_field;

  notify_if nif ();

  wire launch = pending_reg && !nif.busy;
  assign nif.start      = launch;
  assign nif.data_field = field_sel;
  assign nif.tready     = notify_tready;
  assign notify_tdata   = nif.tdata;
  assign notify_tvalid  = nif.tvalid;
  assign notify_tlast   = nif.tlast;

  notify_packer u_packer (
    .clk   (pclk),
    .rst_n (presetn),
    .nif   (nif.packer)
  );

  // a change while a packet is in flight queues exactly one more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= '0;
      prime_reg    <= 3'b000;
      pending_reg  <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync_lvl;
      prime_reg    <= {prime_reg[1:0], 1'b1};
      // a new trigger wins over the launch that clears the request
      if (trigger) begin
        pending_reg <= 1'b1;
      end else if (launch) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // ---------------- apb read
  wire [31:0] rd_mux =
      hit_func   ? {20'h00000, func_reg}                    :
      hit_dir    ? {20'h00000, dir_reg}                     :
      hit_set    ? {26'h0000000, drive_reg}                 :
      hit_level  ? {26'h0000000, pin_sync_lvl}              :
      hit_mask   ? {26'h0000000, mask_reg}                  :
      hit_format ? {31'h00000000, format_reg}               :
      hit_pullup ? {24'h000000, pullup_reg}                 :
      hit_ustat  ? {25'h0000000, uart_line_status}          :
                   32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // the set-up cycle latches read data, so the access phase answers at once
  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // bits 11:6 of set and clear are dropped, as they carry no pin
  wire unused_hi = ^{pwdata[31:PINS], rd_en};
endmodule

// >>> include/gpio_notify_pkg.sv
package gpio_notify_pkg;

  localparam int          NUM_PINS        = 6;
  localparam int          REG_W           = 12;

  // register byte offsets on the APB
  localparam logic [7:0]  OFF_FUNC        = 8'h00;
  localparam logic [7:0]  OFF_DIR         = 8'h04;
  localparam logic [7:0]  OFF_SET         = 8'h08;
  localparam logic [7:0]  OFF_CLEAR       = 8'h0c;
  localparam logic [7:0]  OFF_LEVEL       = 8'h10;
  localparam logic [7:0]  OFF_MASK        = 8'h14;
  localparam logic [7:0]  OFF_FORMAT      = 8'h18;
  localparam logic [7:0]  OFF_PULLUP      = 8'h1c;
  localparam logic [7:0]  OFF_UART_STAT   = 8'h20;

  // pin-function field layout
  localparam int          FUNC_MODE_LSB   = 0;
  localparam int          FUNC_MODE_W     = 3;
  localparam int          FUNC_POL_BIT    = 3;
  localparam int          FUNC_USED_W     = 4;

  // pin-function mode codes
  localparam logic [2:0]  MODE_GPIO       = 3'b000;
  localparam logic [2:0]  MODE_RTS_CTS    = 3'b001;
  localparam logic [2:0]  MODE_DTR_DSR    = 3'b010;
  localparam logic [2:0]  MODE_XCVR_TX    = 3'b011;
  localparam logic [2:0]  MODE_XCVR_ADDR  = 3'b100;

  // reset values
  localparam logic [11:0] RST_FUNC        = 12'h000;
  localparam logic [11:0] RST_DIR         = 12'h000;
  localparam logic [11:0] RST_DRIVE       = 12'h000;
  localparam logic [11:0] RST_MASK        = 12'h03f;
  localparam logic [11:0] RST_FORMAT      = 12'h000;
  localparam logic [11:0] RST_PULLUP      = 12'h000;

  // notification packet
  localparam int          PKT_BYTES       = 10;
  localparam logic [7:0]  PKT_REQ_TYPE    = 8'ha1;
  localparam logic [7:0]  PKT_NOTIFY_CODE = 8'h20;
  localparam logic [15:0] PKT_VALUE       = 16'h0000;
  localparam logic [15:0] PKT_INDEX       = 16'h0000;
  localparam logic [15:0] PKT_LENGTH      = 16'h0002;
  localparam int          PKT_DATA_OFF    = 8;

  // extended data field pin positions
  localparam int          EXT_PIN5_BIT    = 14;
  localparam int          EXT_PIN4_BIT    = 13;
  localparam int          EXT_PIN3_BIT    = 12;
  localparam int          EXT_PIN0_BIT    = 11;
  localparam int          EXT_PIN2_BIT    = 9;
  localparam int          EXT_PIN1_BIT    = 8;

  typedef enum logic [1:0] {
    NS_IDLE = 2'b00,
    NS_SEND = 2'b01,
    NS_DONE = 2'b11
  } notify_state_e;

endpackage

// >>> include/notify_if.sv
interface notify_if;
  import gpio_notify_pkg::*;
  logic              start;
  logic [15:0]       data_field;
  logic              busy;
  logic [7:0]        tdata;
  logic              tvalid;
  logic              tlast;
  logic              tready;

  modport core (
    output start,
    output data_field,
    input  busy
  );
  modport packer (
    input  start,
    input  data_field,
    output busy,
    output tdata,
    output tvalid,
    output tlast,
    input  tready
  );
endinterface

// >>> core/pin_sync.sv
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// >>> core/notify_packer.sv
module notify_packer
  import gpio_notify_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  notify_if.packer  nif
);
  notify_state_e state_reg;
  notify_state_e state_next;
  logic [3:0]    idx_reg;
  logic [3:0]    idx_next;
  logic [15:0]   data_reg;
  logic [7:0]    byte_sel;

  localparam logic [3:0] LAST_IDX = 4'(PKT_BYTES - 1);

  // header then data, every multi-byte field low byte first
  // the byte is picked for the next index, so registered tdata always matches idx_reg
  always_comb begin
    case (idx_next)
      4'h0:    byte_sel = PKT_REQ_TYPE;
      4'h1:    byte_sel = PKT_NOTIFY_CODE;
      4'h2:    byte_sel = PKT_VALUE[7:0];
      4'h3:    byte_sel = PKT_VALUE[15:8];
      4'h4:    byte_sel = PKT_INDEX[7:0];
      4'h5:    byte_sel = PKT_INDEX[15:8];
      4'h6:    byte_sel = PKT_LENGTH[7:0];
      4'h7:    byte_sel = PKT_LENGTH[15:8];
      4'h8:    byte_sel = data_reg[7:0];
      4'h9:    byte_sel = data_reg[15:8];
      default: byte_sel = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    case (state_reg)
      NS_IDLE: begin
        if (nif.start) begin
          state_next = NS_SEND;
          idx_next   = 4'h0;
        end
      end
      NS_SEND: begin
        if (nif.tready) begin
          if (idx_reg == LAST_IDX) begin
            state_next = NS_DONE;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      NS_DONE: state_next = NS_IDLE;
      default: state_next = NS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NS_IDLE;
      idx_reg   <= 4'h0;
      data_reg  <= 16'h0000;
      nif.tdata <= 8'h00;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      // data is captured once so a packet never mixes two snapshots
      if (state_reg == NS_IDLE && nif.start) begin
        data_reg <= nif.data_field;
      end
      nif.tdata <= byte_sel;
    end
  end

  assign nif.tvalid = (state_reg == NS_SEND);
  assign nif.tlast  = (state_reg == NS_SEND) && (idx_reg == LAST_IDX);
  assign nif.busy   = (state_reg != NS_IDLE);
endmodule

// >>> testbench/gpio_notify_chk.sv
module gpio_notify_chk
  import gpio_notify_pkg::*;
#(
  parameter int PINS = NUM_PINS
) (
  // clock, reset and apb
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  // pins
  input wire logic [PINS-1:0] general_pin_n_out,
  input wire logic [PINS-1:0] general_pin_n_oe,
  input wire logic [7:0]      pullup_en,
  input wire logic            uart_transmitting,
  input wire logic            rts_flow_level,
  // notification stream
  input wire logic [7:0]      notify_tdata,
  input wire logic            notify_tvalid,
  input wire logic            notify_tlast,
  input wire logic            notify_tready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  localparam logic [63:0] HDR = 64'h0002_0000_0000_20a1;
  logic [3:0] func_reg;
  logic [5:0] dir_reg;
  logic [5:0] drv_reg;
  logic [7:0] pu_reg;
  logic       fmt_reg;
  logic [3:0] cnt_reg;
  wire        wr        = psel && penable && pwrite;
  wire        beat      = notify_tvalid && notify_tready;
  wire        gpio_mode = func_reg[2:0] == MODE_GPIO;
  // shadow copies of the registers, updated at the same edge as the design's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {func_reg, dir_reg, drv_reg, pu_reg, fmt_reg} <= '0;
    end else if (wr) begin
      if (paddr == OFF_FUNC) func_reg <= pwdata[3:0];
      if (paddr == OFF_DIR) dir_reg <= pwdata[5:0];
      // only output pins take set and clear writes
      if (paddr == OFF_SET) drv_reg <= (drv_reg & ~dir_reg) | (pwdata[5:0] & dir_reg);
      if (paddr == OFF_CLEAR) drv_reg <= drv_reg & ~(pwdata[5:0] & dir_reg);
      if (paddr == OFF_FORMAT) fmt_reg <= pwdata[0];
      if (paddr == OFF_PULLUP) pu_reg <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= '0;
    else if (beat) cnt_reg <= notify_tlast ? 4'h0 : cnt_reg + 4'h1;
  end
  property p_hdr;
    notify_tvalid && !cnt_reg[3] |-> notify_tdata == HDR[{cnt_reg[2:0], 3'b000} +: 8];
  endproperty
  a_hdr: assert property (p_hdr) else $error("header byte wrong");
  property p_last;
    notify_tvalid |-> notify_tlast == (cnt_reg == 4'h9);
  endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_hold;
    notify_tvalid && !notify_tready |=> notify_tvalid && $stable(notify_tdata);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped while stalled");
  property p_std;
    notify_tvalid && !fmt_reg && cnt_reg[3] |->
      !notify_tdata[7] && (cnt_reg == 4'h8 || notify_tdata == 8'h00);
  endproperty
  a_std: assert property (p_std) else $error("standard reserved bits set");
  property p_ext;
    notify_tvalid && fmt_reg && cnt_reg[3] |->
      !notify_tdata[7] && (cnt_reg == 4'h8 || !notify_tdata[2]);
  endproperty
  a_ext: assert property (p_ext) else $error("extended reserved bits set");
  property p_dir;
    gpio_mode [*2] |-> general_pin_n_oe == dir_reg;
  endproperty
  a_dir: assert property (p_dir) else $error("enable differs from direction");
  property p_drv;
    (gpio_mode && $stable({drv_reg, dir_reg})) [*2] |->
      (general_pin_n_out & general_pin_n_oe) == (drv_reg & dir_reg);
  endproperty
  a_drv: assert property (p_drv) else $error("driven level wrong");
  property p_xcvr;
    (func_reg[2:0] == MODE_XCVR_TX && uart_transmitting && $stable(func_reg)) [*3] |->
      general_pin_n_oe[5] && general_pin_n_out[5] == func_reg[FUNC_POL_BIT];
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver level wrong");
  property p_rts;
    (func_reg[2:0] == MODE_RTS_CTS && $stable(rts_flow_level)) [*3] |->
      general_pin_n_oe[5] && !general_pin_n_oe[4] && general_pin_n_out[5] == rts_flow_level;
  endproperty
  a_rts: assert property (p_rts) else $error("flow pins wrong");
  property p_pu;
    $stable(pu_reg) |-> pullup_en == pu_reg;
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up enables wrong");
  c_pkt: cover property (beat && notify_tlast);
  c_ext: cover property (beat && notify_tlast && fmt_reg);
  c_xcvr: cover property (func_reg[2:0] == MODE_XCVR_TX && uart_transmitting);
endmodule

bind gpio_port_change_notify gpio_notify_chk #(.PINS(PINS)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .general_pin_n_out,
  .general_pin_n_oe, .pullup_en, .uart_transmitting, .rts_flow_level,
  .notify_tdata, .notify_tvalid, .notify_tlast, .notify_tready);

// >>> testbench/notify_host_model.sv
module notify_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // stream from the device
  input  wire logic [7:0]  tdata,
  input  wire logic        tvalid,
  input  wire logic        tlast,
  output logic             tready,
  // pacing and capture
  input  wire logic        slow,
  output logic      [79:0] pkt,
  output int               pkt_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pace_reg;
  // a slow host accepts every other cycle to exercise the stall path
  assign tready = !slow || pace_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pace_reg <= 1'b0;
      pkt <= '0;
      pkt_cnt <= 0;
    end else begin
      pace_reg <= !pace_reg;
      // shifting in from the top leaves byte 0 in the low bits
      if (tvalid && tready) pkt <= {tdata, pkt[79:8]};
      if (tvalid && tready && tlast) pkt_cnt <= pkt_cnt + 1;
    end
  end
endmodule

// >>> testbench/gpio_port_change_notify_tb_top.sv
module gpio_port_change_notify_tb_top
  import gpio_notify_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] HDR = 64'h0002_0000_0000_20a1;
  logic        pclk, presetn, psel, penable, pwrite, rerr;
  logic [7:0]  paddr, pullup_en, tdata;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, xmit, rts, dtr, evt, slow, tvalid, tlast, tready, amatch;
  logic [5:0]  pin_lvl, pin_out, pin_oe, ext_val, ext_en;
  logic [6:0]  line_st;
  logic [79:0] pkt;
  int          pkt_cnt, err_count, samples_checked, cycles;
  logic [7:0]  ra [6] = '{OFF_FUNC, OFF_DIR, OFF_SET, OFF_MASK, OFF_FORMAT, OFF_PULLUP};
  logic [11:0] re [6] = '{RST_FUNC, RST_DIR, RST_DRIVE, RST_MASK, RST_FORMAT, RST_PULLUP};

  // pad: device drive wins, then the outside driver, then the pull-up
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pullup_en[5:0]);

  gpio_port_change_notify i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .general_pin_n_in(pin_lvl), .general_pin_n_out(pin_out),
    .general_pin_n_oe(pin_oe), .pullup_en, .uart_transmitting(xmit),
    .uart_addr_matched(amatch), .rts_flow_level(rts), .dtr_flow_level(dtr),
    .uart_line_status(line_st), .notify_tdata(tdata), .notify_tvalid(tvalid),
    .notify_tlast(tlast), .notify_tready(tready), .uart_status_event(evt));

  notify_host_model i_host (.clk(pclk), .rst_n(presetn), .tdata, .tvalid, .tlast,
    .tready, .slow, .pkt, .pkt_cnt);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer, entered just after a rising edge, leaves an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial begin
    {psel, penable, pwrite, xmit, rts, dtr, evt, slow, amatch, presetn} = '0;
    {paddr, pwdata} = '0;
    {ext_val, ext_en, line_st} = {6'h15, 6'h3f, 7'h55};
    {cycles, err_count, samples_checked} = '0;
    cyc(10);
    presetn <= 1'b1;
    cyc(1);
    foreach (ra[i]) rchk(ra[i], {20'h0, re[i]});
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b0, 8'h24, 32'h0);
    chk({rd, rerr}, 33'h1);
    apb(1'b1, OFF_LEVEL, 32'h3f);
    rchk(OFF_LEVEL, 32'h15);
    apb(1'b1, OFF_FUNC, 32'h0);
    apb(1'b1, OFF_DIR, 32'h0f);
    apb(1'b1, OFF_SET, 32'h3c);
    cyc(4);
    rchk(OFF_LEVEL, 32'h1c);
    apb(1'b1, OFF_CLEAR, 32'h24);
    cyc(4);
    rchk(OFF_LEVEL, 32'h18);
    rchk(OFF_SET, 32'h08);
    apb(1'b1, OFF_PULLUP, 32'hff);
    ext_en <= 6'h0f;
    cyc(4);
    chk(pullup_en, 8'hff);
    rchk(OFF_LEVEL, 32'h38);
    apb(1'b1, OFF_PULLUP, 32'h0);
    ext_en <= 6'h3f;
    apb(1'b1, OFF_DIR, 32'h0);
    cyc(4);
    chk(pkt_cnt, 0);
    apb(1'b1, OFF_MASK, 32'h2f);
    slow <= 1'b1;
    ext_val <= 6'h05;
    while (pkt_cnt != 1) @(posedge pclk);
    chk(pkt, {16'h0055, HDR});
    ext_val <= 6'h0d;
    cyc(20);
    chk(pkt_cnt, 1);
    apb(1'b1, OFF_FORMAT, 32'h1);
    evt <= 1'b1;
    cyc(1);
    evt <= 1'b0;
    while (pkt_cnt != 2) @(posedge pclk);
    chk(pkt, {16'h1a55, HDR});
    xmit <= 1'b1;
    apb(1'b1, OFF_FUNC, 32'h3);
    cyc(3);
    chk({pin_oe[5], pin_out[5]}, 2'b10);
    apb(1'b1, OFF_FUNC, 32'hb);
    cyc(3);
    chk({pin_oe[5], pin_out[5]}, 2'b11);
    rts <= 1'b1;
    apb(1'b1, OFF_FUNC, 32'h1);
    cyc(3);
    chk({pin_oe[5:4], pin_out[5]}, 3'b101);
    dtr <= 1'b1;
    apb(1'b1, OFF_FUNC, 32'h2);
    cyc(3);
    chk({pin_oe[3:2], pin_out[3]}, 3'b101);
    apb(1'b1, OFF_FUNC, 32'h4);
    rchk(OFF_FUNC, 32'h4);
    chk({pin_oe[5], pin_out[5]}, 2'b11);
    amatch <= 1'b1;
    cyc(3);
    chk({pin_oe[5], pin_out[5]}, 2'b10);
    rchk(OFF_UART_STAT, 32'h55);
    tally_and_finish();
  end
endmodule
